/* File: hdl/eps_pkg.sv */
/*
 * Constants and types shared by the energy pulse and sag detect block.
 * Assumes 24-bit two's complement samples and active and reactive powers, and unsigned apparent power, from the compute engine.
 */
package eps_pkg;
    // data widths
    localparam int EPS_WORD_W = 24;
    localparam int EPS_PROD_W = 49;
    localparam int EPS_ACC_W = 52;
    localparam int EPS_PW_W = 16;
    localparam int EPS_DUR_W = 16;
    localparam int EPS_DIV_W = 4;
    localparam int EPS_OWR_W = 10;
    // divided clocks per output sample, and per fastest pulse
    localparam int EPS_OWR_DCLKS = 1024;
    localparam int EPS_PULSE_DCLKS = 2048;
    localparam logic [EPS_OWR_W-1:0] EPS_OWR_LAST = EPS_OWR_W'(EPS_OWR_DCLKS - 1);
    // least sample spacing between two pulse starts
    localparam logic [1:0] EPS_MIN_GAP = 2'(EPS_PULSE_DCLKS / EPS_OWR_DCLKS);
    localparam logic [1:0] EPS_GAP_RST = 2'h3;
    // one pulse quantum is 2.0 in the rate-scaled product
    localparam logic signed [EPS_ACC_W-1:0] EPS_QUANTUM = 52'sh1000000000000;
    localparam logic signed [EPS_ACC_W-1:0] EPS_ACC_MAX = 52'sh4000000000000;
    // reset values
    localparam logic [EPS_DIV_W-1:0] EPS_DIV_RST = 4'h0;
    localparam logic [EPS_OWR_W-1:0] EPS_OWR_RST = 10'h000;
    // checker figures in master clocks
    localparam logic [11:0] EPS_E1_GAP_MIN = 12'(EPS_PULSE_DCLKS - 1);
    localparam logic [10:0] EPS_E1_LOW_MIN = 11'(EPS_OWR_DCLKS);
    // third pin source select
    typedef enum logic [1:0] {
        EPS_E3_REACTIVE = 2'h0,
        EPS_E3_SUPPLY = 2'h1,
        EPS_E3_VSIGN = 2'h2,
        EPS_E3_APPARENT = 2'h3
    } eps_e3_mode_type;
    // pulse generator states, one-hot
    typedef enum logic [1:0] {
        EPS_PG_IDLE = 2'h1,
        EPS_PG_LOW = 2'h2
    } eps_pg_state_type;
endpackage

/* File: hdl/eps_pulse_gen.sv */
/*
 * Energy-to-pulse converter: banks signed per-sample energy, emits one
 * active-low pulse per quantum. Assumes a one-cycle sample tick.
 */
`timescale 1ns/10ps
module eps_pulse_gen
    import eps_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // per-sample energy
    input wire logic i_sample_tick,
    input wire logic i_enable,
    input wire logic signed [EPS_PROD_W-1:0] i_energy,
    input wire logic [EPS_PW_W-1:0] i_width,
    // pulse output
    output logic o_pulse_n,
    output logic o_positive
);
    typedef struct packed {
        eps_pg_state_type state;
        logic signed [EPS_ACC_W-1:0] acc;
        logic [EPS_PW_W-1:0] width_cnt;
        logic [1:0] gap;
        logic pulse_n;
        logic positive;
    } eps_pg_reg_type;

    localparam eps_pg_reg_type PG_RST = '{state: EPS_PG_IDLE, acc: '0, width_cnt: '0,
        gap: EPS_GAP_RST, pulse_n: 1'b1, positive: 1'b1};

    eps_pg_reg_type r_q;
    eps_pg_reg_type r_d;

    // accumulate, clamp, and fire on each sample
    always_comb begin
        r_d = r_q;
        if (i_sample_tick) begin
            // R16 - suppressed energy dropped
            if (!i_enable) begin
                r_d.acc = '0;
            end else begin
                r_d.acc = r_q.acc + EPS_ACC_W'(i_energy);
            end
            // clamp so a long pulse width cannot overflow the bank
            if (r_d.acc > EPS_ACC_MAX) begin
                r_d.acc = EPS_ACC_MAX;
            end else if (r_d.acc < -EPS_ACC_MAX) begin
                r_d.acc = -EPS_ACC_MAX;
            end
            if (r_q.gap != EPS_GAP_RST) begin
                r_d.gap = r_q.gap + 2'h1;
            end
            unique case (r_q.state)
                EPS_PG_LOW: begin
                    // R17 - width in samples
                    if (r_q.width_cnt <= 16'h0001) begin
                        r_d.pulse_n = 1'b1;
                        r_d.state = EPS_PG_IDLE;
                    end else begin
                        r_d.width_cnt = r_q.width_cnt - 16'h0001;
                    end
                end
                EPS_PG_IDLE: begin
                    // R4 - two samples between starts
                    if (r_q.gap >= EPS_MIN_GAP &&
                        (r_d.acc >= EPS_QUANTUM || r_d.acc <= -EPS_QUANTUM)) begin
                        // R19 - remainder kept
                        r_d.positive = !r_d.acc[EPS_ACC_W-1];
                        r_d.acc = r_d.positive ? r_d.acc - EPS_QUANTUM : r_d.acc + EPS_QUANTUM;
                        r_d.pulse_n = 1'b0;
                        r_d.state = EPS_PG_LOW;
                        r_d.gap = 2'h1;
                        r_d.width_cnt = (i_width == '0) ? 16'h0001 : i_width;
                    end
                end
                default: begin
                    r_d.state = EPS_PG_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r_q <= PG_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_pulse_n = r_q.pulse_n;
    assign o_positive = r_q.positive;
endmodule

/* File: hdl/eps_sag_detect.sv */
/*
 * Sag or fault detector for one channel: counts low-magnitude samples in a
 * programmed window. Assumes one sample per tick and a one-cycle clear.
 */
`timescale 1ns/10ps
module eps_sag_detect
    import eps_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // samples
    input wire logic i_sample_tick,
    input wire logic [EPS_WORD_W-1:0] i_sample,
    // programming
    input wire logic [EPS_WORD_W-1:0] i_level,
    input wire logic i_level_wr,
    input wire logic [EPS_DUR_W-1:0] i_duration,
    input wire logic i_duration_wr,
    input wire logic i_clear,
    // status
    output logic o_flag
);
    typedef struct packed {
        logic [EPS_WORD_W-1:0] level;
        logic [EPS_DUR_W-1:0] duration;
        logic level_set;
        logic dur_set;
        logic [EPS_DUR_W-1:0] win_cnt;
        logic [EPS_DUR_W-1:0] below_cnt;
        logic flag;
    } eps_sag_reg_type;

    eps_sag_reg_type r_q;
    eps_sag_reg_type r_d;
    logic [EPS_WORD_W-1:0] mag;
    logic armed;

    // window count and flag decision
    always_comb begin
        r_d = r_q;
        mag = i_sample[EPS_WORD_W-1] ? (~i_sample + 24'h000001) : i_sample;
        // R13 - armed by both writes
        // R14 - same for current channel
        armed = r_q.level_set && r_q.dur_set && (r_q.duration != '0);
        if (i_level_wr) begin
            r_d.level = i_level;
            r_d.level_set = 1'b1;
        end
        if (i_duration_wr) begin
            r_d.duration = i_duration;
            r_d.dur_set = 1'b1;
            r_d.win_cnt = '0;
            r_d.below_cnt = '0;
        end
        if (i_clear) begin
            r_d.flag = 1'b0;
        end
        if (armed && i_sample_tick && !i_duration_wr) begin
            // R15 - magnitude vs level per sample
            r_d.win_cnt = r_q.win_cnt + 16'h0001;
            r_d.below_cnt = r_q.below_cnt + ((mag < r_q.level) ? 16'h0001 : 16'h0000);
            if (r_d.win_cnt >= r_q.duration) begin
                // R12 - over half the window; set beats clear
                if ({r_d.below_cnt, 1'b0} > {1'b0, r_q.duration}) begin
                    r_d.flag = 1'b1;
                end
                r_d.win_cnt = '0;
                r_d.below_cnt = '0;
            end
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_flag = r_q.flag;
endmodule

/* File: hdl/eps_energy_pulse.sv */
/*
 * Energy pulse outputs with sag and fault detection: sample timing from
 * the master clock over K, three pulse generators, pin muxing, mask gating.
 * Assumes powers and samples are steady at each sample tick and that all
 * configuration inputs are synchronous to I_MCLK.
 */
`timescale 1ns/10ps
// Operation
// R1 - active-low pulses track active power
// R2 - direction pin shows active energy sign
// R3 - full-scale rate is register times DCLK/2048
// R4 - pulses never faster than DCLK/2048
// R5 - second pin mode selects apparent pulses
// R6 - third pin mode 11b gives apparent
// R7 - apparent pulses track apparent power, unsigned
// R8 - mode 0 gives signed reactive pulses
// R9 - reactive pulses track reactive power
// R10 - mode 10b gives voltage sign level
// R11 - mode 01b follows supply comparator
// R12 - flag when low over half window
// R13 - voltage sag armed after both writes
// R14 - current fault armed after both writes
// R15 - sample magnitudes, window in sample cycles
// R16 - no-load threshold blocks active pulses
// R17 - pulse width is count of samples
// R18 - flag reaches interrupt only when masked in
// R19 - accumulate energy, keep remainder per quantum
module eps_energy_pulse
    import eps_pkg::*;
(
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST,
    // clock divider
    input wire logic [EPS_DIV_W-1:0] I_CLK_DIV_K,
    // computed quantities, two's complement except apparent power, which is unsigned
    input wire logic [EPS_WORD_W-1:0] I_ACTIVE_POWER,
    input wire logic [EPS_WORD_W-1:0] I_REACTIVE_POWER,
    input wire logic [EPS_WORD_W-1:0] I_APPARENT_POWER,
    input wire logic [EPS_WORD_W-1:0] I_VOLTAGE_SAMPLE,
    input wire logic [EPS_WORD_W-1:0] I_CURRENT_SAMPLE,
    input wire logic I_SUPPLY_MONITOR_COMPARATOR,
    // pulse configuration
    input wire logic [EPS_WORD_W-1:0] I_PULSE_RATE_REGISTER,
    input wire logic [EPS_PW_W-1:0] I_PULSE_WIDTH_COUNT,
    input wire logic [EPS_WORD_W-1:0] I_NO_LOAD_THRESHOLD_REGISTER,
    input wire logic I_SECOND_PIN_MODE_BIT,
    input wire logic [1:0] I_THIRD_PIN_MODE_FIELD,
    // voltage sag programming
    input wire logic [EPS_WORD_W-1:0] I_VOLTAGE_SAG_LEVEL_REGISTER,
    input wire logic I_VOLTAGE_SAG_LEVEL_WR,
    input wire logic [EPS_DUR_W-1:0] I_VOLTAGE_SAG_DURATION_REGISTER,
    input wire logic I_VOLTAGE_SAG_DURATION_WR,
    // current fault programming
    input wire logic [EPS_WORD_W-1:0] I_CURRENT_FAULT_LEVEL_REGISTER,
    input wire logic I_CURRENT_FAULT_LEVEL_WR,
    input wire logic [EPS_DUR_W-1:0] I_CURRENT_FAULT_DURATION_REGISTER,
    input wire logic I_CURRENT_FAULT_DURATION_WR,
    // status clear and mask, bit 0 voltage, bit 1 current
    input wire logic [1:0] I_STATUS_CLEAR,
    input wire logic [1:0] I_INT_MASK,
    // energy pins, active low
    output logic O_ACTIVE_ENERGY_PULSE_PIN_N,
    output logic O_DIRECTION_OR_APPARENT_PIN_N,
    output logic O_REACTIVE_MULTI_FUNCTION_PIN_N,
    // status
    output logic O_VOLTAGE_SAG_FLAG,
    output logic O_CURRENT_FAULT_FLAG,
    output logic O_INT_N
);
    typedef struct packed {
        logic [EPS_DIV_W-1:0] div_cnt;
        logic [EPS_OWR_W-1:0] owr_cnt;
        logic sample_tick;
        logic sign_pos;
        logic e1_n;
        logic e2_n;
        logic e3_n;
        logic int_n;
    } eps_top_reg_type;

    localparam eps_top_reg_type TOP_RST = '{div_cnt: EPS_DIV_RST, owr_cnt: EPS_OWR_RST,
        sample_tick: 1'b0, sign_pos: 1'b1, e1_n: 1'b1, e2_n: 1'b1, e3_n: 1'b1,
        int_n: 1'b1};

    eps_top_reg_type r_q;
    eps_top_reg_type r_d;

    logic [EPS_DIV_W-1:0] k_last;
    logic dclk_tick;
    logic signed [EPS_WORD_W:0] rate_s;
    logic signed [EPS_PROD_W-1:0] act_energy;
    logic signed [EPS_PROD_W-1:0] rea_energy;
    logic signed [EPS_PROD_W-1:0] app_energy;
    logic [EPS_WORD_W-1:0] act_mag;
    logic active_en;
    logic act_n;
    logic act_pos;
    logic rea_n;
    logic rea_pos;
    logic app_n;
    logic app_pos;
    logic volt_flag;
    logic curr_flag;
    logic int_req;
    eps_e3_mode_type e3_mode;

    // divider: K of zero behaves as one
    always_comb begin
        k_last = (I_CLK_DIV_K == '0) ? 4'h0 : I_CLK_DIV_K - 4'h1;
        dclk_tick = (r_q.div_cnt >= k_last);
    end

    // R3 - rate scaling
    // unsigned rate widened so the signed product keeps its sign
    assign rate_s = $signed({1'b0, I_PULSE_RATE_REGISTER});
    assign act_energy = $signed(I_ACTIVE_POWER) * rate_s;
    assign rea_energy = $signed(I_REACTIVE_POWER) * rate_s;
    assign app_energy = $signed({1'b0, I_APPARENT_POWER}) * rate_s;

    // R16 - no-load gate
    // magnitude of most negative word still fits unsigned
    always_comb begin
        act_mag = I_ACTIVE_POWER[EPS_WORD_W-1] ? (~I_ACTIVE_POWER + 24'h000001)
            : I_ACTIVE_POWER;
        active_en = (act_mag >= I_NO_LOAD_THRESHOLD_REGISTER);
    end

    // R1 - active energy converter
    eps_pulse_gen u_active (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_sample_tick(r_q.sample_tick),
        .i_enable(active_en),
        .i_energy(act_energy),
        .i_width(I_PULSE_WIDTH_COUNT),
        .o_pulse_n(act_n),
        .o_positive(act_pos)
    );

    // R9 - reactive energy converter
    eps_pulse_gen u_reactive (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_sample_tick(r_q.sample_tick),
        .i_enable(1'b1),
        .i_energy(rea_energy),
        .i_width(I_PULSE_WIDTH_COUNT),
        .o_pulse_n(rea_n),
        .o_positive(rea_pos)
    );

    // R7 - apparent converter, never negative
    eps_pulse_gen u_apparent (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_sample_tick(r_q.sample_tick),
        .i_enable(1'b1),
        .i_energy(app_energy),
        .i_width(I_PULSE_WIDTH_COUNT),
        .o_pulse_n(app_n),
        .o_positive(app_pos)
    );

    // voltage sag channel
    eps_sag_detect u_volt_sag (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_sample_tick(r_q.sample_tick),
        .i_sample(I_VOLTAGE_SAMPLE),
        .i_level(I_VOLTAGE_SAG_LEVEL_REGISTER),
        .i_level_wr(I_VOLTAGE_SAG_LEVEL_WR),
        .i_duration(I_VOLTAGE_SAG_DURATION_REGISTER),
        .i_duration_wr(I_VOLTAGE_SAG_DURATION_WR),
        .i_clear(I_STATUS_CLEAR[0]),
        .o_flag(volt_flag)
    );

    // current fault channel
    eps_sag_detect u_curr_fault (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_sample_tick(r_q.sample_tick),
        .i_sample(I_CURRENT_SAMPLE),
        .i_level(I_CURRENT_FAULT_LEVEL_REGISTER),
        .i_level_wr(I_CURRENT_FAULT_LEVEL_WR),
        .i_duration(I_CURRENT_FAULT_DURATION_REGISTER),
        .i_duration_wr(I_CURRENT_FAULT_DURATION_WR),
        .i_clear(I_STATUS_CLEAR[1]),
        .o_flag(curr_flag)
    );

    assign O_VOLTAGE_SAG_FLAG = volt_flag;
    assign O_CURRENT_FAULT_FLAG = curr_flag;
    assign e3_mode = eps_e3_mode_type'(I_THIRD_PIN_MODE_FIELD);
    // R18 - mask gating
    assign int_req = |({curr_flag, volt_flag} & I_INT_MASK);

    // sample timing, pin muxing and interrupt
    always_comb begin
        r_d = r_q;
        r_d.sample_tick = 1'b0;
        if (dclk_tick) begin
            r_d.div_cnt = EPS_DIV_RST;
            r_d.owr_cnt = r_q.owr_cnt + 10'h001;
            // R15 - one tick per output sample
            r_d.sample_tick = (r_q.owr_cnt == EPS_OWR_LAST);
        end else begin
            r_d.div_cnt = r_q.div_cnt + 4'h1;
        end
        r_d.e1_n = act_n;
        // R2 - sign taken on a new fall
        // active wins if both fall together; reactive sign then lost
        if (!act_n && r_q.e1_n) begin
            r_d.sign_pos = act_pos;
        end else if (e3_mode == EPS_E3_REACTIVE && !rea_n && r_q.e3_n) begin
            // R8 - reactive sign
            r_d.sign_pos = rea_pos;
        end
        // R5 - second pin source
        r_d.e2_n = I_SECOND_PIN_MODE_BIT ? app_n : r_d.sign_pos;
        unique case (e3_mode)
            EPS_E3_REACTIVE: begin
                r_d.e3_n = rea_n;
            end
            EPS_E3_SUPPLY: begin
                // R11 - comparator level
                r_d.e3_n = I_SUPPLY_MONITOR_COMPARATOR;
            end
            EPS_E3_VSIGN: begin
                // R10 - high while positive
                r_d.e3_n = !I_VOLTAGE_SAMPLE[EPS_WORD_W-1];
            end
            EPS_E3_APPARENT: begin
                // R6 - apparent on third pin
                r_d.e3_n = app_n;
            end
        endcase
        r_d.int_n = !int_req;
    end

    // state register
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            r_q <= TOP_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign O_ACTIVE_ENERGY_PULSE_PIN_N = r_q.e1_n;
    assign O_DIRECTION_OR_APPARENT_PIN_N = r_q.e2_n;
    assign O_REACTIVE_MULTI_FUNCTION_PIN_N = r_q.e3_n;
    assign O_INT_N = r_q.int_n;

    // checker helpers: cycles since last E1 fall and E1 low length
    logic [11:0] e1_gap_cnt;
    logic [10:0] e1_low_cnt;
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            e1_gap_cnt <= 12'hFFF;
            e1_low_cnt <= 11'h000;
        end else begin
            if (!r_q.e1_n && r_d.e1_n == 1'b0 && e1_low_cnt == 11'h000) begin
                e1_gap_cnt <= 12'h000;
            end else if (e1_gap_cnt != 12'hFFF) begin
                e1_gap_cnt <= e1_gap_cnt + 12'h001;
            end
            if (!r_q.e1_n) begin
                e1_low_cnt <= (e1_low_cnt == 11'h7FF) ? e1_low_cnt : e1_low_cnt + 11'h001;
            end else begin
                e1_low_cnt <= 11'h000;
            end
        end
    end

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);

    a_e1_pulse_spacing: assert property ( // R4
        $fell(O_ACTIVE_ENERGY_PULSE_PIN_N) |-> e1_gap_cnt >= EPS_E1_GAP_MIN)
        else $error("active pulses closer than 2048 clocks");
    a_e1_pulse_width: assert property ( // R17
        $rose(O_ACTIVE_ENERGY_PULSE_PIN_N) |-> e1_low_cnt >= EPS_E1_LOW_MIN)
        else $error("active pulse shorter than one sample");
    a_no_load_block: assert property ( // R16
        $fell(O_ACTIVE_ENERGY_PULSE_PIN_N) |-> $past(active_en, 2))
        else $error("active pulse while below no-load threshold");
    a_dir_sign_set: assert property ( // R2
        $fell(O_ACTIVE_ENERGY_PULSE_PIN_N) && !$past(I_SECOND_PIN_MODE_BIT)
        |-> O_DIRECTION_OR_APPARENT_PIN_N == $past(act_pos))
        else $error("direction pin wrong at active pulse");
    a_e2_apparent_sel: assert property ( // R5
        !$past(I_RST) && $past(I_SECOND_PIN_MODE_BIT)
        |-> O_DIRECTION_OR_APPARENT_PIN_N == $past(app_n))
        else $error("second pin not carrying apparent pulses");
    a_e3_apparent_sel: assert property ( // R6
        !$past(I_RST) && $past(e3_mode) == EPS_E3_APPARENT
        |-> O_REACTIVE_MULTI_FUNCTION_PIN_N == $past(app_n))
        else $error("third pin not carrying apparent pulses");
    a_e3_reactive_sel: assert property ( // R8
        !$past(I_RST) && $past(e3_mode) == EPS_E3_REACTIVE
        |-> O_REACTIVE_MULTI_FUNCTION_PIN_N == $past(rea_n))
        else $error("third pin not carrying reactive pulses");
    a_e3_voltage_sign: assert property ( // R10
        !$past(I_RST) && $past(e3_mode) == EPS_E3_VSIGN
        |-> O_REACTIVE_MULTI_FUNCTION_PIN_N != $past(I_VOLTAGE_SAMPLE[EPS_WORD_W-1]))
        else $error("third pin does not show voltage sign");
    a_e3_supply_mon: assert property ( // R11
        !$past(I_RST) && $past(e3_mode) == EPS_E3_SUPPLY
        |-> O_REACTIVE_MULTI_FUNCTION_PIN_N == $past(I_SUPPLY_MONITOR_COMPARATOR))
        else $error("third pin does not follow supply comparator");
    a_int_mask_gate: assert property ( // R18
        !$past(I_RST) |-> O_INT_N == !$past(int_req))
        else $error("interrupt pin disagrees with masked flags");

    c_active_pulse: cover property ($fell(O_ACTIVE_ENERGY_PULSE_PIN_N));
    c_reactive_pulse: cover property (
        $fell(O_REACTIVE_MULTI_FUNCTION_PIN_N) && e3_mode == EPS_E3_REACTIVE);
    c_apparent_e2: cover property (
        $fell(O_DIRECTION_OR_APPARENT_PIN_N) && I_SECOND_PIN_MODE_BIT);
    c_voltage_sag: cover property ($rose(O_VOLTAGE_SAG_FLAG));
endmodule

/* File: testbench/eps_pulse_counter.sv */
/*
 * Far-side pulse counter: counts falling edges on the three energy pins.
 * Assumes one clock shared with the block and a clear pulse per window.
 */
`timescale 1ns/10ps
module eps_pulse_counter (
    // clock and window clear
    input wire logic i_clk,
    input wire logic i_clr,
    // energy pins, active low
    input wire logic i_e1_n,
    input wire logic i_e2_n,
    input wire logic i_e3_n,
    // tallies
    output int o_n1,
    output int o_n2,
    output int o_n3,
    output int o_pos1,
    output int o_pos3,
    output int o_gap1
);
    logic e1_q = 1'b1;
    logic e2_q = 1'b1;
    logic e3_q = 1'b1;
    int since1 = 0;
    // edge tally; direction is read at the edge after the fall, once it has settled
    always @(posedge i_clk) begin
        e1_q <= i_e1_n;
        e2_q <= i_e2_n;
        e3_q <= i_e3_n;
        since1 <= since1 + 1;
        if (i_clr) begin
            o_n1 <= 0;
            o_n2 <= 0;
            o_n3 <= 0;
            o_pos1 <= 0;
            o_pos3 <= 0;
            o_gap1 <= 1000000;
        end else begin
            if (e1_q && !i_e1_n) begin
                o_n1 <= o_n1 + 1;
                o_pos1 <= o_pos1 + int'(i_e2_n);
                if (o_n1 > 0 && since1 < o_gap1) begin
                    o_gap1 <= since1;
                end
                since1 <= 1;
            end
            if (e2_q && !i_e2_n) begin
                o_n2 <= o_n2 + 1;
            end
            if (e3_q && !i_e3_n) begin
                o_n3 <= o_n3 + 1;
                o_pos3 <= o_pos3 + int'(i_e2_n);
            end
        end
    end
endmodule

/* File: testbench/eps_energy_pulse_tb.sv */
/*
 * Self-checking bench for the energy pulse block, K and pulse width mostly 1.
 * Assumes the pulse counter model sits on the three energy pins.
 */
`timescale 1ns/10ps
module eps_energy_pulse_tb;
    import eps_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ctr_clr = 1'b1;
    logic [23:0] p_act = 24'h000000;
    logic [23:0] p_rea = 24'h000000;
    logic [23:0] p_app = 24'h000000;
    logic [23:0] v_smp = 24'h000000;
    logic [23:0] i_smp = 24'h000000;
    logic [23:0] noload = 24'h000000;
    logic [23:0] lvl = 24'h001000;
    logic [15:0] dur = 16'h0004;
    logic cmp = 1'b0;
    logic e2_mode = 1'b0;
    logic v_lw = 1'b0;
    logic v_dw = 1'b0;
    logic i_lw = 1'b0;
    logic i_dw = 1'b0;
    logic [1:0] e3_mode = 2'h0;
    logic [1:0] clr = 2'h0;
    logic [1:0] mask = 2'h0;
    logic [3:0] div_k = 4'h1;
    logic [15:0] p_wid = 16'h0001;
    logic e1_n, e2_n, e3_n, vflag, iflag, int_n;
    int n1, n2, n3, pos1, pos3, gap1;
    int fails = 0;
    int checked = 0;

    // 20 MHz master clock
    always #25 clk = ~clk;

    // rate is unsigned Q0.24: all ones gives one pulse per two samples at full scale
    eps_energy_pulse i_dut (.I_MCLK(clk), .I_RST(rst), .I_CLK_DIV_K(div_k),
        .I_ACTIVE_POWER(p_act), .I_REACTIVE_POWER(p_rea), .I_APPARENT_POWER(p_app),
        .I_VOLTAGE_SAMPLE(v_smp), .I_CURRENT_SAMPLE(i_smp), .I_SUPPLY_MONITOR_COMPARATOR(cmp),
        .I_PULSE_RATE_REGISTER(24'hFFFFFF), .I_PULSE_WIDTH_COUNT(p_wid),
        .I_NO_LOAD_THRESHOLD_REGISTER(noload), .I_SECOND_PIN_MODE_BIT(e2_mode),
        .I_THIRD_PIN_MODE_FIELD(e3_mode), .I_VOLTAGE_SAG_LEVEL_REGISTER(lvl),
        .I_VOLTAGE_SAG_LEVEL_WR(v_lw), .I_VOLTAGE_SAG_DURATION_REGISTER(dur),
        .I_VOLTAGE_SAG_DURATION_WR(v_dw), .I_CURRENT_FAULT_LEVEL_REGISTER(lvl),
        .I_CURRENT_FAULT_LEVEL_WR(i_lw), .I_CURRENT_FAULT_DURATION_REGISTER(dur),
        .I_CURRENT_FAULT_DURATION_WR(i_dw), .I_STATUS_CLEAR(clr), .I_INT_MASK(mask),
        .O_ACTIVE_ENERGY_PULSE_PIN_N(e1_n), .O_DIRECTION_OR_APPARENT_PIN_N(e2_n),
        .O_REACTIVE_MULTI_FUNCTION_PIN_N(e3_n), .O_VOLTAGE_SAG_FLAG(vflag),
        .O_CURRENT_FAULT_FLAG(iflag), .O_INT_N(int_n));

    eps_pulse_counter i_cnt (.i_clk(clk), .i_clr(ctr_clr), .i_e1_n(e1_n), .i_e2_n(e2_n),
        .i_e3_n(e3_n), .o_n1(n1), .o_n2(n2), .o_n3(n3), .o_pos1(pos1), .o_pos3(pos3),
        .o_gap1(gap1));

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    // clear the tallies, then let n output samples pass
    task automatic window(input int n);
        ctr_clr = 1'b1;
        @(negedge clk);
        ctr_clr = 1'b0;
        repeat (n * EPS_OWR_DCLKS) @(negedge clk);
    endtask

    task automatic results;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // active pulses: full scale both signs, half scale, no-load gate
    task automatic t_active;
        check(e1_n === 1'b1 && e2_n === 1'b1 && int_n === 1'b1, "pins after reset");
        p_act = 24'h7FFFFF;
        window(8);
        check(n1 >= 3 && n1 <= 4, "full scale count");
        check(pos1 === n1, "positive sign");
        check(gap1 >= EPS_PULSE_DCLKS, "pulse spacing");
        p_act = 24'h800001;
        window(8);
        check(n1 >= 3 && n1 <= 4 && pos1 === 0, "negative sign");
        p_act = 24'h400000;
        window(8);
        check(n1 >= 1 && n1 <= 3, "half scale count");
        p_act = 24'h7FFFFF;
        noload = 24'hFFFFFF;
        window(6);
        check(n1 === 0, "no-load gate");
        p_act = 24'h000000;
        noload = 24'h000000;
    endtask

    // second and third pin modes: pulse sources, comparator level, voltage sign
    task automatic t_modes;
        p_app = 24'hFFFFFF;
        e2_mode = 1'b1;
        window(8);
        check(n2 >= 3 && n2 <= 4 && n1 === 0, "apparent on second pin");
        e2_mode = 1'b0;
        for (int s = 0; s < 2; s++) begin
            p_rea = (s == 0) ? 24'h7FFFFF : 24'h800001;
            window(8);
            check(n3 >= 3 && n3 <= 4, "reactive count");
            check(pos3 === ((s == 0) ? n3 : 0), "reactive sign");
        end
        p_rea = 24'h000000;
        e3_mode = 2'h3;
        // let the mode switch settle so its own fall is not counted
        repeat (EPS_OWR_DCLKS) @(negedge clk);
        window(6);
        check(n3 >= 2 && n3 <= 3, "apparent on third pin");
        e3_mode = 2'h1;
        cmp = 1'b1;
        repeat (3) @(negedge clk);
        check(e3_n === 1'b1, "comparator high");
        cmp = 1'b0;
        repeat (3) @(negedge clk);
        check(e3_n === 1'b0, "comparator low");
        e3_mode = 2'h2;
        v_smp = 24'h800000;
        repeat (3) @(negedge clk);
        check(e3_n === 1'b0, "voltage negative");
        v_smp = 24'h100000;
        repeat (3) @(negedge clk);
        check(e3_n === 1'b1, "voltage positive");
    endtask

    // sag and fault: arming, flag, mask, clear
    task automatic t_sag;
        v_smp = 24'h000010;
        i_smp = 24'h000010;
        v_lw = 1'b1;
        i_lw = 1'b1;
        i_dw = 1'b1;
        @(negedge clk);
        v_lw = 1'b0;
        i_lw = 1'b0;
        i_dw = 1'b0;
        window(6);
        check(vflag === 1'b0, "sag unarmed");
        check(iflag === 1'b1, "fault flag");
        mask = 2'h2;
        repeat (2) @(negedge clk);
        check(int_n === 1'b0, "masked-in interrupt");
        v_dw = 1'b1;
        @(negedge clk);
        v_dw = 1'b0;
        window(6);
        check(vflag === 1'b1, "sag flag");
        mask = 2'h0;
        repeat (2) @(negedge clk);
        check(int_n === 1'b1, "masked-out interrupt");
        v_smp = 24'h7FFFFF;
        i_smp = 24'h7FFFFF;
        window(6);
        check(vflag === 1'b1 && iflag === 1'b1, "flags sticky");
        clr = 2'h3;
        @(negedge clk);
        clr = 2'h0;
        repeat (2) @(negedge clk);
        check(vflag === 1'b0 && iflag === 1'b0, "flags cleared");
    endtask

    // K=2 and width 2 stretch an apparent pulse on E3 to 4 * 1024 clocks
    task automatic t_scale;
        int low_len;
        div_k = 4'h2;
        p_wid = 16'h0002;
        e3_mode = 2'h3;
        repeat (2) @(negedge clk);
        while (e3_n !== 1'b1) @(negedge clk);
        while (e3_n !== 1'b0) @(negedge clk);
        low_len = 0;
        while (e3_n === 1'b0) begin
            @(negedge clk);
            low_len++;
        end
        check(low_len == 4 * EPS_OWR_DCLKS, "pulse width with K=2");
        div_k = 4'h1;
        p_wid = 16'h0001;
    endtask

    // main sequence
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_active();
        t_modes();
        t_sag();
        t_scale();
        results();
    end

    // watchdog, a little beyond the expected run
    initial begin
        #(98000 * 50);
        fails++;
        results();
    end
endmodule
